// file: src/acq_ddc_beam.v
/*
  Acquisition path: three downconverting channels with phase and gain,
  power meters, threshold detectors, a beam summer and a gate-driven
  DMA metadata builder, all reached over classic Wishbone.
  Assumes converter, test and loopback samples already on sys_clk_in;
  gate and sync arrive from the timing bus and are synchronised here.
*/
`timescale 1ns/1ps
module acq_ddc_beam #(
  parameter NCH = 3,
  parameter DW = 16,
  parameter CH_ID0 = 4'h1
) (
  input wire sys_clk_in,
  input wire rst_in,
  input wire [31:0] wb_adr_in,
  input wire [31:0] wb_dat_in,
  input wire [3:0] wb_sel_in,
  input wire wb_we_in,
  input wire wb_cyc_in,
  input wire wb_stb_in,
  output reg [31:0] wb_dat_out,
  output reg wb_ack_out,
  input wire [3*DW-1:0] adc_data_in,
  input wire [DW-1:0] test_data_in,
  input wire [DW-1:0] loop_data_in,
  input wire gate_in,
  input wire sync_in,
  input wire [47:0] chain_sum_in,
  input wire chain_valid_in,
  output reg [47:0] chain_sum_out,
  output reg chain_valid_out,
  output reg [NCH*48-1:0] ch_data_out,
  output reg [NCH-1:0] ch_valid_out,
  output reg [NCH-1:0] capture_done_out,
  output reg [63:0] meta_out,
  output reg meta_valid_out,
  output reg xfer_end_out,
  output reg irq_out
);
`include "acq_ddc_regs.vh"

  // Timing-bus inputs cross from the board clock tree
  reg gate_m, gate_s, gate_d, sync_m, sync_s;
  reg [47:0] stamp;
  reg [31:0] next_dat;
  reg [31:0] dma_ctrl, sum_ctrl, sum_thresh, meta0, meta1;
  reg [23:0] gate_count;
  reg [NCH:0] irq_stat;
  reg xfer_active;
  wire wb_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  wire wr = wb_req & wb_we_in;
  wire [7:0] a = wb_adr_in[7:0];
  wire [31:0] wmask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};

  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      gate_m <= 1'b0;
      gate_s <= 1'b0;
      gate_d <= 1'b0;
      sync_m <= 1'b0;
      sync_s <= 1'b0;
      stamp <= 48'h0000_0000_0000;
    end else begin
      gate_m <= gate_in;
      gate_s <= gate_m;
      gate_d <= gate_s;
      sync_m <= sync_in;
      sync_s <= sync_m;
      // Sync zeroes the sample counter so stamps line up across boards
      stamp <= sync_s ? 48'h0000_0000_0000 : stamp + 48'h0000_0000_0001;
    end
  end

  wire gate_rise = gate_s & ~gate_d;
  wire gate_fall = ~gate_s & gate_d;

  // Per-channel state, driven from the generate loop
  wire [31:0] ch_rdata [0:NCH-1];
  wire [NCH-1:0] ch_ev;
  wire [NCH*48-1:0] ch_iq;
  wire [NCH-1:0] ch_v;
  wire [NCH-1:0] ch_done;

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : chan
      localparam [7:0] BASE = `CH_BASE + g * `CH_STRIDE;
      reg [31:0] ctrl, tune, decim, phgain, thresh;
      reg [3:0] avg_shift;
      reg [17:0] coef;
      reg [31:0] phase;
      reg [16:0] dcount;
      reg signed [47:0] acc_i, acc_q;
      reg signed [23:0] out_i, out_q;
      reg ovalid;
      reg [47:0] pwr;
      reg above, done;
      reg signed [DW-1:0] smp;
      wire hit = wb_req && (a[7:5] == BASE[7:5]) && (a < `SUM_CTRL);
      wire [7:0] off = a - BASE;
      wire [16:0] nmax = (decim[16:0] < `MIN_DECIM) ? `MIN_DECIM : decim[16:0];
      // Quadrature mixer uses the phase accumulator sign bits as a coarse LO
      wire signed [DW:0] mix_i = phase[31] ? -$signed({smp[DW-1], smp}) : {smp[DW-1], smp};
      wire signed [DW:0] mix_q = phase[30] ^ phase[31] ? -$signed({smp[DW-1], smp}) : {smp[DW-1], smp};
      wire signed [15:0] gain = phgain[31:16];
      wire signed [15:0] pmix = phgain[15:0];
      wire signed [39:0] adj_i = out_i * gain - out_q * pmix;
      wire signed [39:0] adj_q = out_q * gain + out_i * pmix;
      wire signed [23:0] ai = adj_i[37:14];
      wire signed [23:0] aq = adj_q[37:14];
      wire [47:0] inst = ai * ai + aq * aq;

      // Out-of-range factors are stored clamped, so software reads back what runs
      wire [31:0] dec_new = (decim & ~wmask) | (wb_dat_in & wmask);
      wire [31:0] dec_wr = (dec_new < {15'h0000, `MIN_DECIM}) ? `RST_DECIM :
                           (dec_new > `MAX_DECIM) ? `MAX_DECIM :
                           dec_new;
      wire [3:0] avg_new = (wb_dat_in[3:0] > `MAX_AVG_SHIFT) ? `MAX_AVG_SHIFT : wb_dat_in[3:0];
      // Narrow mode keeps the top 16 bits of each half, sign-extended into the lane
      wire [23:0] ni = {{8{ai[23]}}, ai[23:8]};
      wire [23:0] nq = {{8{aq[23]}}, aq[23:8]};

      always @* begin
        case (ctrl[`CTRL_SRC_MSB:`CTRL_SRC_LSB])
          `SRC_ADC0: smp = adc_data_in[DW-1:0];
          `SRC_ADC1: smp = adc_data_in[2*DW-1:DW];
          `SRC_ADC2: smp = adc_data_in[3*DW-1:2*DW];
          `SRC_TEST: smp = test_data_in;
          default: smp = loop_data_in;
        endcase
      end

      always @(posedge sys_clk_in) begin
        if (rst_in) begin
          ctrl <= 32'h0000_0000;
          tune <= 32'h0000_0000;
          decim <= `RST_DECIM;
          coef <= `RST_COEF;
          phgain <= {`RST_GAIN, 16'h0000};
          avg_shift <= `RST_AVG;
          thresh <= 32'h0000_0000;
          phase <= 32'h0000_0000;
          dcount <= 17'h0_0000;
          acc_i <= 48'h0000_0000_0000;
          acc_q <= 48'h0000_0000_0000;
          out_i <= 24'h00_0000;
          out_q <= 24'h00_0000;
          ovalid <= 1'b0;
          pwr <= 48'h0000_0000_0000;
          above <= 1'b0;
          done <= 1'b0;
        end else begin
          if (wr && hit) begin
            case (off)
              `CH_CTRL: ctrl <= (ctrl & ~wmask) | (wb_dat_in & wmask);
              `CH_TUNE: tune <= (tune & ~wmask) | (wb_dat_in & wmask);
              `CH_DECIM: decim <= dec_wr;
              `CH_COEF: coef <= wb_dat_in[17:0];
              `CH_PHGAIN: phgain <= (phgain & ~wmask) | (wb_dat_in & wmask);
              `CH_AVG: avg_shift <= avg_new;
              `CH_THRESH: thresh <= (thresh & ~wmask) | (wb_dat_in & wmask);
              default: ;
            endcase
          end
          phase <= phase + tune;
          ovalid <= 1'b0;
          if (ctrl[`CTRL_ENABLE]) begin
            // A single tap scales the boxcar; full filter shapes are not modelled
            // Boxcar integrate-and-dump weighted by the loaded tap
            if (dcount + 17'h0_0001 >= nmax) begin
              dcount <= 17'h0_0000;
              out_i <= acc_i[40:17];
              out_q <= acc_q[40:17];
              ovalid <= ~done;
              acc_i <= mix_i * $signed({1'b0, coef});
              acc_q <= mix_q * $signed({1'b0, coef});
            end else begin
              dcount <= dcount + 17'h0_0001;
              acc_i <= acc_i + mix_i * $signed({1'b0, coef});
              acc_q <= acc_q + mix_q * $signed({1'b0, coef});
            end
          end
          // One-shot mode stops after the gate closes; FIFO mode streams on
          if (ctrl[`CTRL_ONESHOT] && gate_fall)
            done <= 1'b1;
          else if (wr && hit && off == `CH_CTRL)
            done <= 1'b0;
          if (ovalid) begin
            // Exponential average: time constant is 2^shift samples, up to 8K
            pwr <= pwr + (inst >> avg_shift) - (pwr >> avg_shift);
            above <= (pwr[47:16] > thresh);
          end
        end
      end

      assign ch_ev[g] = ovalid & ((pwr[47:16] > thresh) != above);
      assign ch_iq[g*48 +: 48] = ctrl[`CTRL_NARROW] ? {ni, nq} : {ai, aq};
      assign ch_v[g] = ovalid;
      assign ch_done[g] = done;
      assign ch_rdata[g] = (off == `CH_CTRL) ? ctrl :
                           (off == `CH_TUNE) ? tune :
                           (off == `CH_DECIM) ? decim :
                           (off == `CH_COEF) ? {14'h0000, coef} :
                           (off == `CH_PHGAIN) ? phgain :
                           (off == `CH_AVG) ? {28'h000_0000, avg_shift} :
                           (off == `CH_THRESH) ? thresh :
                           pwr[47:16];
    end
  endgenerate

  // Beam summer on the latest adjusted channel words
  reg signed [47:0] beam;
  reg signed [47:0] bpwr;
  reg babove;
  reg bvalid;
  wire signed [25:0] s0 = sum_ctrl[`SUM_SEL_LSB] ? {{2{ch_iq[47]}}, ch_iq[47:24]} : 26'h000_0000;
  wire signed [25:0] s1 = sum_ctrl[`SUM_SEL_LSB+1] ? {{2{ch_iq[95]}}, ch_iq[95:72]} : 26'h000_0000;
  wire signed [25:0] s2 = sum_ctrl[`SUM_SEL_MSB] ? {{2{ch_iq[143]}}, ch_iq[143:120]} : 26'h000_0000;
  wire signed [25:0] sq0 = sum_ctrl[`SUM_SEL_LSB] ? {{2{ch_iq[23]}}, ch_iq[23:0]} : 26'h000_0000;
  wire signed [25:0] sq1 = sum_ctrl[`SUM_SEL_LSB+1] ? {{2{ch_iq[71]}}, ch_iq[71:48]} : 26'h000_0000;
  wire signed [25:0] sq2 = sum_ctrl[`SUM_SEL_MSB] ? {{2{ch_iq[119]}}, ch_iq[119:96]} : 26'h000_0000;
  wire signed [25:0] si = s0 + s1 + s2;
  wire signed [25:0] sq = sq0 + sq1 + sq2;
  wire [1:0] sh = sum_ctrl[`SUM_SHIFT_MSB:`SUM_SHIFT_LSB];
  wire signed [25:0] gi = si >>> sh;
  wire signed [25:0] gq = sq >>> sh;
  // Partial sum from the previous board joins the local beam
  wire signed [23:0] ci = gi[23:0] + (chain_valid_in ? chain_sum_in[47:24] : 24'h00_0000);
  wire signed [23:0] cq = gq[23:0] + (chain_valid_in ? chain_sum_in[23:0] : 24'h00_0000);
  wire [47:0] binst = ci * ci + cq * cq;

  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      beam <= 48'h0000_0000_0000;
      bvalid <= 1'b0;
      bpwr <= 48'h0000_0000_0000;
      babove <= 1'b0;
    end else begin
      // Beam follows channel 0 cadence; summed channels should share its decimation
      bvalid <= sum_ctrl[`SUM_ENABLE] & ch_v[0];
      if (sum_ctrl[`SUM_ENABLE] & ch_v[0]) begin
        beam <= {ci, cq};
        bpwr <= bpwr + (binst >> `RST_AVG) - (bpwr >> `RST_AVG);
        babove <= (bpwr[47:16] > sum_thresh);
      end
    end
  end
  wire beam_ev = bvalid & ((bpwr[47:16] > sum_thresh) != babove);

  // Global register strobes
  wire wr_sum_ctrl = wr && (a == `SUM_CTRL);
  wire wr_sum_thresh = wr && (a == `SUM_THRESH);
  wire wr_dma_ctrl = wr && (a == `DMA_CTRL);
  wire wr_irq = wr && (a == `IRQ_STATUS);
  wire [NCH:0] irq_clr = wr_irq ? wb_dat_in[NCH:0] : {(NCH+1){1'b0}};

  // Gate mode stops on the gate; fixed mode stops on the programmed length
  wire len_reached = gate_count >= dma_ctrl[`DMA_LEN_MSB:`DMA_LEN_LSB];
  wire gate_stop = dma_ctrl[`DMA_GATE_MODE] & gate_fall;
  wire count_stop = ~dma_ctrl[`DMA_GATE_MODE] & len_reached;
  wire xfer_stop = gate_stop | count_stop;

  // Bus, DMA metadata and outputs
  always @* begin
    next_dat = 32'h0000_0000;
    if (a < `SUM_CTRL)
      next_dat = ch_rdata[a[6:5]];
    else if (a == `SUM_CTRL)
      next_dat = sum_ctrl;
    else if (a == `SUM_THRESH)
      next_dat = sum_thresh;
    else if (a == `SUM_POWER)
      next_dat = bpwr[47:16];
    else if (a == `IRQ_STATUS)
      next_dat = {{(31-NCH){1'b0}}, irq_stat};
    else if (a == `DMA_CTRL)
      next_dat = dma_ctrl;
    else if (a == `DMA_META0)
      next_dat = meta0;
    else if (a == `DMA_META1)
      next_dat = meta1;
    else if (a == `DMA_STATUS)
      next_dat = {7'h00, xfer_active, gate_count};
  end

  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
      sum_ctrl <= 32'h0000_0000;
      sum_thresh <= 32'h0000_0000;
      dma_ctrl <= 32'h0000_0000;
      irq_stat <= {(NCH+1){1'b0}};
      irq_out <= 1'b0;
      gate_count <= 24'h00_0000;
      xfer_active <= 1'b0;
      meta0 <= 32'h0000_0000;
      meta1 <= 32'h0000_0000;
      meta_out <= 64'h0000_0000_0000_0000;
      meta_valid_out <= 1'b0;
      xfer_end_out <= 1'b0;
      ch_data_out <= {(NCH*48){1'b0}};
      ch_valid_out <= {NCH{1'b0}};
      capture_done_out <= {NCH{1'b0}};
      chain_sum_out <= 48'h0000_0000_0000;
      chain_valid_out <= 1'b0;
    end else begin
      wb_ack_out <= wb_req;
      wb_dat_out <= wb_req ? next_dat : 32'h0000_0000;
      if (wr_sum_ctrl)
        sum_ctrl <= wb_dat_in;
      if (wr_sum_thresh)
        sum_thresh <= wb_dat_in;
      if (wr_dma_ctrl)
        dma_ctrl <= wb_dat_in;
      // Write one to clear; a new event in the same cycle wins
      irq_stat <= (irq_stat & ~irq_clr) | {beam_ev, ch_ev};
      // Pin trails status by a cycle so it comes straight from a flop
      irq_out <= |irq_stat;
      meta_valid_out <= 1'b0;
      xfer_end_out <= 1'b0;
      if (gate_rise) begin
        xfer_active <= 1'b1;
        gate_count <= 24'h00_0000;
        meta0 <= stamp[31:0];
        meta1 <= {CH_ID0, stamp[47:32], 12'h000};
      end else if (xfer_active) begin
        if (ch_v[0])
          gate_count <= gate_count + 24'h00_0001;
        if (xfer_stop) begin
          xfer_active <= 1'b0;
          xfer_end_out <= 1'b1;
          meta_valid_out <= dma_ctrl[`DMA_META_EN];
          meta_out <= {CH_ID0, 4'h0, gate_count, meta0};
        end
      end
      // Module 1 buffer carries the beam when the summer is enabled
      ch_data_out <= sum_ctrl[`SUM_ENABLE] ? {ch_iq[NCH*48-1:48], beam} : ch_iq;
      ch_valid_out <= sum_ctrl[`SUM_ENABLE] ? {ch_v[NCH-1:1], bvalid} : ch_v;
      capture_done_out <= ch_done;
      chain_sum_out <= beam;
      chain_valid_out <= bvalid;
    end
  end
endmodule // acq_ddc_beam

// file: include/acq_ddc_regs.vh
/*
  Register map, field positions, reset values and constants for the
  acquisition, downconversion and beamforming block.
  Assumes a 32-bit classic Wishbone slave with word-aligned byte addresses.
*/
`ifndef ACQ_DDC_REGS_VH
`define ACQ_DDC_REGS_VH

// Per-channel register bank: channel n occupies CH_BASE + n * CH_STRIDE
`define CH_BASE 8'h00
`define CH_STRIDE 8'h20
`define CH_CTRL 8'h00
`define CH_TUNE 8'h04
`define CH_DECIM 8'h08
`define CH_COEF 8'h0C
`define CH_PHGAIN 8'h10
`define CH_AVG 8'h14
`define CH_THRESH 8'h18
`define CH_POWER 8'h1C
// Global registers
`define SUM_CTRL 8'h60
`define SUM_THRESH 8'h64
`define SUM_POWER 8'h68
`define IRQ_STATUS 8'h6C
`define DMA_CTRL 8'h70
`define DMA_META0 8'h74
`define DMA_META1 8'h78
`define DMA_STATUS 8'h7C

// CH_CTRL fields
`define CTRL_SRC_LSB 0
`define CTRL_SRC_MSB 2
`define CTRL_ONESHOT 3
`define CTRL_NARROW 4
`define CTRL_ENABLE 5
// Input source codes
`define SRC_ADC0 3'h0
`define SRC_ADC1 3'h1
`define SRC_ADC2 3'h2
`define SRC_TEST 3'h3
`define SRC_LOOP 3'h4
// SUM_CTRL fields
`define SUM_SEL_LSB 0
`define SUM_SEL_MSB 2
`define SUM_SHIFT_LSB 4
`define SUM_SHIFT_MSB 5
`define SUM_ENABLE 8
// DMA_CTRL fields
`define DMA_GATE_MODE 0
`define DMA_META_EN 1
`define DMA_LEN_LSB 8
`define DMA_LEN_MSB 31
// PHGAIN fields: gain high half, phase-mix low half
`define PG_GAIN_LSB 16
`define PG_PHASE_LSB 0

// Reset values and limits
`define RST_DECIM 32'h0000_0002
`define RST_GAIN 16'h4000
`define RST_AVG 4'hD
`define MAX_AVG_SHIFT 4'hD
`define MIN_DECIM 17'h0_0002
`define MAX_DECIM 32'h0001_0000
`define RST_COEF 18'h0_8000

`endif

// file: test/acq_ddc_beam_assertions.sv
/* Port checker for acq_ddc_beam: bus answer timing, decimated valid
   spacing and transfer-end metadata. Assumes one clock, sync reset. */
`timescale 1ns/1ps
module acq_ddc_beam_assertions #(
  parameter NCH = 3,
  parameter DW = 16,
  parameter CH_ID0 = 4'h1
) (
  input wire sys_clk_in,
  input wire rst_in,
  input wire wb_cyc_in,
  input wire wb_stb_in,
  input wire [31:0] wb_dat_out,
  input wire wb_ack_out,
  input wire [NCH-1:0] ch_valid_out,
  input wire [63:0] meta_out,
  input wire meta_valid_out,
  input wire xfer_end_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  sequence req_taken;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  sequence ack_once;
    wb_ack_out ##1 !wb_ack_out;
  endsequence
  sequence end_once;
    xfer_end_out ##1 !xfer_end_out;
  endsequence
  chk_ack_next_cycle: assert property (req_taken |=> ack_once)
    else $error("ack late or held");
  chk_ack_needs_req: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
    else $error("ack without request");
  chk_rdata_idle: assert property (!wb_ack_out |-> wb_dat_out == 32'h0000_0000)
    else $error("read data outside ack");
  chk_valid_spaced: assert property (ch_valid_out[0] |=> !ch_valid_out[0])
    else $error("valid faster than fs/2");
  chk_end_pulse: assert property (xfer_end_out |-> end_once)
    else $error("transfer end held");
  chk_meta_at_end: assert property (meta_valid_out |-> xfer_end_out)
    else $error("metadata apart from transfer end");
  chk_meta_pulse: assert property (meta_valid_out |=> !meta_valid_out)
    else $error("metadata valid held");
  chk_meta_pad: assert property (meta_valid_out |-> meta_out[59:56] == 4'h0)
    else $error("metadata pad not zero");
endmodule // acq_ddc_beam_assertions
bind acq_ddc_beam acq_ddc_beam_assertions #(.NCH(NCH), .DW(DW), .CH_ID0(CH_ID0)) chk_i (
  .sys_clk_in(sys_clk_in),
  .rst_in(rst_in),
  .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in),
  .wb_dat_out(wb_dat_out),
  .wb_ack_out(wb_ack_out),
  .ch_valid_out(ch_valid_out),
  .meta_out(meta_out),
  .meta_valid_out(meta_valid_out),
  .xfer_end_out(xfer_end_out)
);

// file: test/acq_ddc_src_model.sv
/* Source side model: random samples on one live source, sync in reset,
   gates of given length, partial beam every other cycle.
   Assumes the bench picks the source and asks for gates. */
`timescale 1ns/1ps
module acq_ddc_src_model (
  input wire sys_clk_in,
  input wire rst_in,
  input wire [2:0] live_in,
  input wire go_in,
  input wire [15:0] glen_in,
  output reg [47:0] adc_out,
  output reg [15:0] test_out,
  output reg [15:0] loop_out,
  output reg gate_out,
  output reg sync_out,
  output reg [47:0] chain_out,
  output reg chain_valid_out
);
  integer pseed = 32'h0000_04c1;
  reg [15:0] s;
  reg [15:0] left = 16'h0000;
  initial begin
    {adc_out, test_out, loop_out, gate_out, sync_out, chain_out, chain_valid_out} = 0;
  end
  always @(posedge sys_clk_in) begin
    // Never zero, so a live source always shows downstream
    s = $random(pseed) | 16'h0101;
    adc_out <= {live_in == 3'h2 ? s : 16'h0000, live_in == 3'h1 ? s : 16'h0000,
      live_in == 3'h0 ? s : 16'h0000};
    test_out <= live_in == 3'h3 ? s : 16'h0000;
    loop_out <= live_in == 3'h4 ? s : 16'h0000;
    sync_out <= rst_in;
    if (go_in) begin
      left <= glen_in;
    end else if (left != 16'h0000) begin
      left <= left - 16'h0001;
    end
    gate_out <= left != 16'h0000;
    chain_valid_out <= ~chain_valid_out;
    // Invalid cycles carry inverted data so stale values cannot pass
    chain_out <= chain_valid_out ? ~chain_out : {16'h0000, s[7:0], 16'h0000, s[7:0]};
  end
endmodule // acq_ddc_src_model

// file: test/acq_ddc_beam_test.sv
/* Self-checking bench for acq_ddc_beam over classic Wishbone.
   Assumes the source model and the bound checker. */
`timescale 1ns/1ps
`include "acq_ddc_regs.vh"
module acq_ddc_beam_test;
  logic sys_clk_in = 0, rst_in = 1, cyc = 0, stb = 0, we = 0, go = 0;
  logic [31:0] adr = 0, wd = 0, q, v, dq;
  logic [7:0] b;
  logic [2:0] live = 0, chv, cdone;
  logic [47:0] adc, csi, cso;
  logic [15:0] tst, lpb;
  logic [143:0] chd;
  logic [63:0] meta;
  logic ack, gate, sync, cvi, cvo, mv, xe, irq;
  integer seed = 32'h0000_04c1, n_mismatch = 0, samples_checked = 0, i, k, n;
  always #5 sys_clk_in = ~sys_clk_in;
  acq_ddc_beam dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .wb_adr_in(adr), .wb_dat_in(wd),
    .wb_sel_in(4'hF), .wb_we_in(we), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_dat_out(dq),
    .wb_ack_out(ack), .adc_data_in(adc), .test_data_in(tst), .loop_data_in(lpb), .gate_in(gate),
    .sync_in(sync), .chain_sum_in(csi), .chain_valid_in(cvi), .chain_sum_out(cso),
    .chain_valid_out(cvo), .ch_data_out(chd), .ch_valid_out(chv), .capture_done_out(cdone),
    .meta_out(meta), .meta_valid_out(mv), .xfer_end_out(xe), .irq_out(irq));
  acq_ddc_src_model src (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .live_in(live), .go_in(go),
    .glen_in(16'h0064), .adc_out(adc), .test_out(tst), .loop_out(lpb), .gate_out(gate),
    .sync_out(sync), .chain_out(csi), .chain_valid_out(cvi));
  task wrap_up;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    k = 0;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= {24'h00_0000, a};
    wd <= d;
    @(posedge sys_clk_in);
    while (ack !== 1'b1 && k < 20) begin
      @(posedge sys_clk_in);
      k++;
    end
    if (k >= 20) begin
      chk("wb ack", 1, 0);
      wrap_up;
    end
    q = dq;
    cyc <= 0;
    stb <= 0;
    we <= 0;
    @(posedge sys_clk_in);
  endtask
  // Bounded wait for ch0 samples, or count them over a fixed window
  task vwait(input integer cnt, input integer win);
    n = 0;
    k = 0;
    while ((win > 0 ? k < win : n < cnt) && k < 9000) begin
      @(posedge sys_clk_in);
      k++;
      if (chv[0] === 1'b1) n++;
    end
    if (k >= 9000) begin
      chk("valid wait", 1, 0);
      wrap_up;
    end
  endtask
  function integer per_window(input integer d);
    per_window = 420 / d;
  endfunction
  initial begin
    repeat (8) @(posedge sys_clk_in);
    rst_in <= 0;
    @(posedge sys_clk_in);
    for (i = 0; i < 3; i++) begin
      b = {i[2:0], 5'h00};
      wb(0, b + `CH_DECIM, 0); chk("decim rst", `RST_DECIM, q);
      wb(0, b + `CH_COEF, 0); chk("coef rst", {14'h0000, `RST_COEF}, q);
      wb(0, b + `CH_PHGAIN, 0); chk("gain rst", {`RST_GAIN, 16'h0000}, q & 32'hFFFF_0000);
      wb(0, b + `CH_AVG, 0); chk("avg rst", {28'h000_0000, `RST_AVG}, q);
      v = $random(seed);
      wb(1, b + `CH_TUNE, v); wb(0, b + `CH_TUNE, 0); chk("tune", v, q);
      v = $random(seed) & 32'h0003_FFFF;
      wb(1, b + `CH_COEF, v); wb(0, b + `CH_COEF, 0); chk("coef", v, q);
      // A random tap may be tiny; later scenarios need a live signal path
      wb(1, b + `CH_COEF, `RST_COEF);
      wb(1, b + `CH_DECIM, 1); wb(0, b + `CH_DECIM, 0); chk("decim min", `RST_DECIM, q);
      wb(1, b + `CH_DECIM, 32'h0001_0000); wb(0, b + `CH_DECIM, 0); chk("decim max", 32'h0001_0000, q);
    end
    wb(1, 8'h80, 32'hFFFF_FFFF); wb(0, 8'h80, 0); chk("unmapped", 0, q);
    wb(1, `CH_DECIM, 2);
    for (i = 0; i < 5; i++) begin
      live <= i[2:0];
      wb(1, `CH_CTRL, 32'h0000_0020 | i); vwait(8, 0); chk("src live", 1, chd[47:0] !== 0);
      wb(1, `CH_CTRL, 32'h0000_0020 | ((i + 1) % 5)); vwait(8, 0); chk("src idle", 1, chd[47:0] === 0);
    end
    live <= 0;
    wb(1, `CH_CTRL, 32'h0000_0020);
    for (i = 2; i < 8; i++) begin
      wb(1, `CH_DECIM, i); vwait(3, 0); vwait(0, 420); chk("rate", per_window(i), n);
    end
    wb(1, `CH_AVG, 2);
    wb(1, `CH_THRESH, 32'hFFFF_FFFF);
    vwait(20, 0);
    wb(1, `IRQ_STATUS, 32'h0000_000F);
    wb(0, `CH_POWER, 0); chk("power", 1, q !== 0);
    wb(1, `CH_THRESH, 0);
    for (k = 0; k < 300 && irq !== 1'b1; k++) @(posedge sys_clk_in);
    chk("irq", 1, irq);
    wb(0, `IRQ_STATUS, 0); chk("irq ch0", 1, q[0]);
    wb(1, `IRQ_STATUS, 1); wb(0, `IRQ_STATUS, 0); chk("irq clear", 0, q[0]);
    wb(1, `SUM_CTRL, 32'h0000_0107); vwait(0, 100);
    wb(0, `SUM_POWER, 0); chk("beam power", 1, q !== 0);
    wb(1, `CH_DECIM, 4);
    for (i = 0; i < 2; i++) begin
      wb(1, `DMA_CTRL, i ? 32'h0000_0001 : 32'h0000_0003);
      go <= 1;
      @(posedge sys_clk_in);
      go <= 0;
      for (k = 0; k < 1000 && xe !== 1'b1; k++) @(posedge sys_clk_in);
      chk("end after gate", 1, xe === 1'b1 && gate === 1'b0);
      chk("meta valid", i ? 0 : 1, mv);
      if (i == 0) chk("meta len", 1, meta[55:32] >= 24 && meta[55:32] <= 26);
    end
    // Fixed-length transfer of 10 samples, ends before the gate does
    wb(1, `DMA_CTRL, 32'h0000_0A02);
    go <= 1;
    @(posedge sys_clk_in);
    go <= 0;
    for (k = 0; k < 1000 && xe !== 1'b1; k++) @(posedge sys_clk_in);
    chk("fixed end", 1, xe);
    chk("fixed gate", 1, gate);
    chk("fixed len", 32'h0000_000A, meta[55:32]);
    chk("meta id", 4'h1, meta[63:60]);
    for (k = 0; k < 300 && gate !== 1'b0; k++) @(posedge sys_clk_in);
    // Beam leaves on the chain port with the same word as module 1 buffer
    vwait(2, 0);
    chk("chain beam", chd[31:0], cso[31:0]);
    chk("chain valid", chv[0], cvo);
    wb(1, `SUM_CTRL, 0);
    wb(1, `CH_CTRL, 32'h0000_0030);
    vwait(4, 0);
    chk("narrow sign", 1, chd[47:40] === {8{chd[39]}} && chd[23:16] === {8{chd[15]}});
    wb(1, `CH_CTRL, 32'h0000_0028);
    go <= 1;
    @(posedge sys_clk_in);
    go <= 0;
    for (k = 0; k < 1000 && cdone[0] !== 1'b1; k++) @(posedge sys_clk_in);
    chk("oneshot done", 1, cdone[0]);
    vwait(0, 40);
    chk("oneshot stop", 0, n);
    wrap_up;
  end
endmodule // acq_ddc_beam_test
